// file: hw/ple_cluster.v
// ten-element programmable logic cluster with an axi4-lite configuration slave
//
// Overview of operation
// - each element has a four-input lookup with a sixteen-bit truth table
// - each flip-flop configurable as D, T, JK or SR
// - asynchronous load takes its value from the fourth data input
// - combinational result bypasses the flip-flop straight to the outputs
// - three outputs per element, each picks lookup or flip-flop
// - packing option feeds the flip-flop back into its own lookup
// - register cascade feeds the next element's flip-flop input
// - subtract inverts every B operand bit and forces carry in high
// - adder lsb sits at chain start, carry set by add/subtract select
// - normal mode lookup uses data inputs, carry or fourth input selectable
// - normal mode result cascades to the next element directly
// - arithmetic mode precomputes sums and carries for carry zero and one
// - cluster carry picks the chain, chain level picks the sum
// - each chain carry in selects its own chain carry out
// - counter enable, up/down from data inputs; sync clear/load cluster-wide
// - a carry chain may start at any element
// - selecting carry regenerated at fifth and tenth elements
// - carry continues to the adjacent cluster of the same row
// - preset is async load of one; clear beats preset/load; two clears
// - chip-wide clear resets all, overrides all; its power-up hold drops at the first clock, as reset leaves it disabled
// - with chip-wide clear disabled the pin is a plain input
// - flip-flops power up low, as reset also clears the power-up-high configuration bit
// - exactly ten elements share the cluster controls
// - deasserted clock enable stops that cluster clock
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ple_cluster_map.vh"

module ple_cluster (
    input  wire        aclk,                 // clock
    input  wire        aresetn,              // sync reset
    input  wire [7:0]  s_axi_awaddr,         // aw addr
    input  wire        s_axi_awvalid,        // aw valid
    output reg         s_axi_awready,        // aw ready
    input  wire [31:0] s_axi_wdata,          // w data
    input  wire [3:0]  s_axi_wstrb,          // w strobes
    input  wire        s_axi_wvalid,         // w valid
    output reg         s_axi_wready,         // w ready
    output reg  [1:0]  s_axi_bresp,          // b code
    output reg         s_axi_bvalid,         // b valid
    input  wire        s_axi_bready,         // b ready
    input  wire [7:0]  s_axi_araddr,         // ar addr
    input  wire        s_axi_arvalid,        // ar valid
    output reg         s_axi_arready,        // ar ready
    output reg  [31:0] s_axi_rdata,          // r data
    output reg  [1:0]  s_axi_rresp,          // r code
    output reg         s_axi_rvalid,         // r valid
    input  wire        s_axi_rready,         // r ready
    input  wire [39:0] data_in,              // element data
    input  wire [1:0]  cluster_clk,          // clocks
    input  wire [1:0]  cluster_clk_en,       // enables
    input  wire [1:0]  async_clear,          // clears
    input  wire        async_load,           // preset/load
    input  wire        sync_clear,           // sync clear
    input  wire        sync_load,            // sync load
    input  wire        cluster_carry_in,     // prior carry
    input  wire        zero_chain_carry_in,  // prior zero chain
    input  wire        one_chain_carry_in,   // prior one chain
    input  wire        reg_chain_in,         // prior reg cascade
    input  wire        lut_chain_in,         // prior lut cascade
    input  wire        chip_wide_clear_n,    // clear pin
    output reg  [9:0]  le_out_local,         // output one
    output reg  [9:0]  le_out_row,           // output two
    output reg  [9:0]  le_out_col,           // output three
    output reg         zero_chain_carry_out, // zero chain
    output reg         one_chain_carry_out,  // one chain
    output reg         cluster_carry_out,    // regen carry
    output reg         reg_chain_out,        // reg cascade
    output reg         lut_chain_out,        // lut cascade
    output reg         gp_pin_level          // pin level
);

    // software state
    reg  [31:0]                ctrl_ff;
    reg  [`PLE_CFG_WIDTH-1:0]  cfg_ff [0:`PLE_NUM_ELEM-1];
    reg  [9:0]                 q_ff;
    reg                        init_done_ff;
    reg                        hold_ff;
    reg  [1:0]                 clk_prev_ff;
    reg                        aw_got_ff;
    reg                        w_got_ff;
    reg  [7:0]                 aw_addr_ff;
    reg  [31:0]                w_data_ff;
    reg  [3:0]                 w_strb_ff;

    // per-element combinational nets
    wire [9:0]  c0_in;
    wire [9:0]  c1_in;
    wire [9:0]  c0_out;
    wire [9:0]  c1_out;
    wire [9:0]  comb;
    wire [9:0]  nxt_q;
    wire [9:0]  lut_prev;
    wire [9:0]  q_prev;
    wire        sub_sel;
    wire        chip_clr;
    wire        carry_mid;
    wire        carry_top;
    wire [1:0]  tick;

    assign sub_sel  = ctrl_ff[`PLE_CTRL_SUB];
    // chip clear acts only when enabled; otherwise the pin is a plain input
    assign chip_clr = ctrl_ff[`PLE_CTRL_CLR_EN] & ~chip_wide_clear_n;
    // enabled rising edge of each cluster clock
    assign tick     = cluster_clk & ~clk_prev_ff & cluster_clk_en;
    // carry regeneration points after the fifth and tenth element
    assign carry_mid = cluster_carry_in ? c1_out[4] : c0_out[4];
    assign carry_top = carry_mid ? c1_out[9] : c0_out[9];
    assign lut_prev = {comb[8:0], lut_chain_in};
    assign q_prev   = {q_ff[8:0], reg_chain_in};

    // byte-lane merge for bus writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  st;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (st[k])
                    merge[k*8 +: 8] = wd[k*8 +: 8];
        end
    endfunction

    // one logic element per iteration, all sharing cluster controls
    genvar i;
    generate
        for (i = 0; i < `PLE_NUM_ELEM; i = i + 1)
        begin : g_le
            wire [`PLE_CFG_WIDTH-1:0] cfg;
            wire       d0;
            wire       d1;
            wire       d2;
            wire       d3;
            wire       start;
            wire       grp_carry;
            wire       cin0;
            wire       cin1;
            wire       a;
            wire       b;
            wire       sel;
            wire       in0;
            wire       in1;
            wire       in3;
            wire [3:0] idx;
            wire       lut;
            wire       sum;
            wire       din;
            wire [1:0] fft;
            wire       clk_tick;
            wire       upd;
            reg        fnext;

            assign cfg   = cfg_ff[i];
            assign d0    = data_in[4*i];
            assign d1    = data_in[4*i+1];
            assign d2    = data_in[4*i+2];
            assign d3    = data_in[4*i+3];
            assign start = cfg[`PLE_CFG_CHAIN_START] | (i == 0);
            assign grp_carry = (i < `PLE_REGEN_ELEM) ? cluster_carry_in : carry_mid;

            // chain start forces both chains to the add/subtract carry
            if (i == 0)
            begin : g_first
                assign cin0 = cfg[`PLE_CFG_CHAIN_START] ? sub_sel : zero_chain_carry_in;
                assign cin1 = cfg[`PLE_CFG_CHAIN_START] ? sub_sel : one_chain_carry_in;
            end
            else if (i == `PLE_REGEN_ELEM)
            begin : g_regen
                assign cin0 = start ? sub_sel : 1'b0;
                assign cin1 = start ? sub_sel : 1'b1;
            end
            else
            begin : g_mid
                assign cin0 = start ? sub_sel : c0_out[i-1];
                assign cin1 = start ? sub_sel : c1_out[i-1];
            end
            assign c0_in[i] = cin0;
            assign c1_in[i] = cin1;

            // operands: B inverted on subtract, or on count-down from d3
            assign a   = d0;
            assign b   = d1 ^ sub_sel ^ (cfg[`PLE_CFG_ARITH] & d3);
            assign c0_out[i] = (a & b) | ((a ^ b) & cin0);
            assign c1_out[i] = (a & b) | ((a ^ b) & cin1);
            assign sel = grp_carry ? cin1 : cin0;
            assign sum = sel ? (a ^ b ^ cin1) : (a ^ b ^ cin0);

            // normal mode lookup inputs
            assign in0 = cfg[`PLE_CFG_LUTCHAIN] ? lut_prev[i] : d0;
            assign in1 = cfg[`PLE_CFG_PACK] ? q_ff[i] : d1;
            assign in3 = cfg[`PLE_CFG_CARRY_IN3] ? sel : d3;
            assign idx = {in3, d2, in1, in0};
            assign lut = cfg[`PLE_CFG_MASK_LO + idx];
            assign comb[i] = cfg[`PLE_CFG_ARITH] ? sum : lut;

            // flip-flop data input and behaviour
            assign din = cfg[`PLE_CFG_REGCHAIN] ? q_prev[i] : comb[i];
            assign fft = cfg[`PLE_CFG_FFT_HI:`PLE_CFG_FFT_LO];
            assign clk_tick = tick[cfg[`PLE_CFG_CLK_SEL]];
            // in arithmetic mode d2 is the counter enable
            assign upd = clk_tick & (~cfg[`PLE_CFG_ARITH] | d2);

            always @*
            begin
                case (fft)
                    `PLE_FF_D:  fnext = din;
                    `PLE_FF_T:  fnext = q_ff[i] ^ din;
                    `PLE_FF_JK: fnext = (din & ~q_ff[i]) | (~d3 & q_ff[i]);
                    `PLE_FF_SR: fnext = din | (~d3 & q_ff[i]);
                    default:    fnext = din;
                endcase
            end

            // priority: power-up, chip clear, async clear, async load, sync
            assign nxt_q[i] = !init_done_ff ? cfg[`PLE_CFG_PU_HIGH] :
                              (chip_clr | hold_ff) ? 1'b0 :
                              async_clear[cfg[`PLE_CFG_ACLR_SEL]] ? 1'b0 :
                              async_load ? (cfg[`PLE_CFG_PRESET] | d3) :
                              !clk_tick ? q_ff[i] :
                              sync_clear ? 1'b0 :
                              sync_load ? d3 :
                              upd ? fnext : q_ff[i];
        end
    endgenerate

    // element state, power-up sequencing and cluster clock history
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_ff         <= 10'h000;
            init_done_ff <= 1'b0;
            hold_ff      <= 1'b1;
            clk_prev_ff  <= 2'h0;
        end
        else
        begin
            q_ff         <= nxt_q;
            init_done_ff <= 1'b1;
            clk_prev_ff  <= cluster_clk;
            // clears stay held until the pin rises or the function is off
            if (chip_wide_clear_n | ~ctrl_ff[`PLE_CTRL_CLR_EN])
                hold_ff <= 1'b0;
        end
    end

    // registered element and cascade outputs
    integer e;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            le_out_local         <= 10'h000;
            le_out_row           <= 10'h000;
            le_out_col           <= 10'h000;
            zero_chain_carry_out <= 1'b0;
            one_chain_carry_out  <= 1'b0;
            cluster_carry_out    <= 1'b0;
            reg_chain_out        <= 1'b0;
            lut_chain_out        <= 1'b0;
            gp_pin_level         <= 1'b0;
        end
        else
        begin
            for (e = 0; e < `PLE_NUM_ELEM; e = e + 1)
            begin
                // each output independently picks lookup or flip-flop
                le_out_local[e] <= cfg_ff[e][`PLE_CFG_OSEL_LO]     ? q_ff[e] : comb[e];
                le_out_row[e]   <= cfg_ff[e][`PLE_CFG_OSEL_LO + 1] ? q_ff[e] : comb[e];
                le_out_col[e]   <= cfg_ff[e][`PLE_CFG_OSEL_HI]     ? q_ff[e] : comb[e];
            end
            zero_chain_carry_out <= c0_out[9];
            one_chain_carry_out  <= c1_out[9];
            cluster_carry_out    <= carry_top;
            reg_chain_out        <= q_ff[9];
            lut_chain_out        <= comb[9];
            gp_pin_level         <= chip_wide_clear_n;
        end
    end

    // write channel: address and data taken in either order
    wire        wr_cfg;
    wire [3:0]  wr_idx;
    wire [31:0] cfg_wr;
    assign cfg_wr = merge({1'b0, cfg_ff[wr_idx]}, w_data_ff, w_strb_ff);
    assign wr_idx = aw_addr_ff[5:2];
    assign wr_cfg = (aw_addr_ff[7:6] == 2'h1) && (aw_addr_ff[1:0] == 2'h0)
                    && (wr_idx < 4'hA);
    integer r;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PLE_RESP_OKAY;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            aw_addr_ff    <= 8'h00;
            w_data_ff     <= 32'h00000000;
            w_strb_ff     <= 4'h0;
            ctrl_ff       <= `PLE_CTRL_RST;
            for (r = 0; r < `PLE_NUM_ELEM; r = r + 1)
                cfg_ff[r] <= `PLE_CFG_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff     <= 1'b1;
                aw_addr_ff    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff     <= 1'b1;
                w_data_ff    <= s_axi_wdata;
                w_strb_ff    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_ff && w_got_ff && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PLE_RESP_OKAY;
                if (aw_addr_ff == `PLE_CTRL_OFS)
                    ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & 32'h00000003;
                else if (wr_cfg)
                    cfg_ff[wr_idx] <= cfg_wr[`PLE_CFG_WIDTH-1:0];
                else if (aw_addr_ff != `PLE_STATUS_OFS)
                    s_axi_bresp <= `PLE_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_got_ff     <= 1'b0;
                w_got_ff      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: answer one cycle after the address is taken
    wire [3:0] rd_idx;
    wire       rd_cfg;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_cfg = (s_axi_araddr[7:6] == 2'h1) && (s_axi_araddr[1:0] == 2'h0)
                    && (rd_idx < 4'hA);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `PLE_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PLE_RESP_OKAY;
            if (s_axi_araddr == `PLE_CTRL_OFS)
                s_axi_rdata <= ctrl_ff;
            else if (s_axi_araddr == `PLE_STATUS_OFS)
                s_axi_rdata <= {18'h00000, hold_ff, chip_wide_clear_n, chip_clr,
                                carry_top, q_ff};
            else if (rd_cfg)
                s_axi_rdata <= {1'b0, cfg_ff[rd_idx]};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `PLE_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // ple_cluster
`default_nettype wire

// file: hw/ple_cluster_map.vh
// register offsets, field positions and reset values of the logic cluster
`ifndef PLE_CLUSTER_MAP_VH
`define PLE_CLUSTER_MAP_VH

// geometry
`define PLE_NUM_ELEM        10
`define PLE_REGEN_ELEM      5

// register byte offsets
`define PLE_CTRL_OFS        8'h00
`define PLE_STATUS_OFS      8'h04
`define PLE_CFG_BASE        8'h40

// control register fields
`define PLE_CTRL_CLR_EN     0
`define PLE_CTRL_SUB        1
`define PLE_CTRL_RST        32'h00000000

// per-element configuration fields
`define PLE_CFG_MASK_LO     0
`define PLE_CFG_MASK_HI     15
`define PLE_CFG_ARITH       16
`define PLE_CFG_FFT_LO      17
`define PLE_CFG_FFT_HI      18
`define PLE_CFG_CARRY_IN3   19
`define PLE_CFG_PACK        20
`define PLE_CFG_OSEL_LO     21
`define PLE_CFG_OSEL_HI     23
`define PLE_CFG_REGCHAIN    24
`define PLE_CFG_PU_HIGH     25
`define PLE_CFG_CLK_SEL     26
`define PLE_CFG_ACLR_SEL    27
`define PLE_CFG_CHAIN_START 28
`define PLE_CFG_LUTCHAIN    29
`define PLE_CFG_PRESET      30
`define PLE_CFG_WIDTH       31
`define PLE_CFG_RST         31'h00000000

// flip-flop behaviours
`define PLE_FF_D            2'h0
`define PLE_FF_T            2'h1
`define PLE_FF_JK           2'h2
`define PLE_FF_SR           2'h3

// status register fields
`define PLE_ST_CARRY        10
`define PLE_ST_CHIPCLR      11
`define PLE_ST_PIN          12
`define PLE_ST_HOLD         13

// bus responses
`define PLE_RESP_OKAY       2'h0
`define PLE_RESP_SLVERR     2'h2

`endif

// file: sim/ple_cluster_chk.sv
// bus handshake and pin assertions for the logic cluster
`timescale 1ns/10ps
`default_nettype none
module ple_cluster_chk (
    input wire logic        aclk, // clock
    input wire logic        aresetn, // reset
    input wire logic        s_axi_awvalid, // aw
    input wire logic        s_axi_awready, // aw
    input wire logic        s_axi_wvalid, // w
    input wire logic        s_axi_wready, // w
    input wire logic [1:0]  s_axi_bresp, // b
    input wire logic        s_axi_bvalid, // b
    input wire logic        s_axi_bready, // b
    input wire logic        s_axi_arvalid, // ar
    input wire logic        s_axi_arready, // ar
    input wire logic [31:0] s_axi_rdata, // r
    input wire logic [1:0]  s_axi_rresp, // r
    input wire logic        s_axi_rvalid, // r
    input wire logic        s_axi_rready, // r
    input wire logic        chip_wide_clear_n, // pin
    input wire logic        gp_pin_level // pin copy
);
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // responses stand until taken, then readys return
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("b dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("r dropped");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
        && s_axi_awready && s_axi_wready) else $error("w not freed");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        && s_axi_arready) else $error("r not freed");
    // write answers two edges after the take, read one
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("b late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("r late");
    AST_ONE_WR: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h00000000) else $error("error data");
    AST_PIN_COPY: assert property ($past(aresetn) |->
        gp_pin_level == $past(chip_wide_clear_n)) else $error("pin copy");
endmodule // ple_cluster_chk

bind ple_cluster ple_cluster_chk u_chk (.*);
`default_nettype wire

// file: sim/ple_nbr_model.sv
// neighbouring cluster and routing that feed the cluster inputs
`timescale 1ns/10ps
`default_nettype none
module ple_nbr_model (
    input  wire logic        aclk,                // clock
    output var  logic [39:0] data_in,             // routed data
    output var  logic        cluster_carry_in,    // prior carry
    output var  logic        zero_chain_carry_in, // prior zero chain
    output var  logic        one_chain_carry_in,  // prior one chain
    output var  logic        reg_chain_in,        // prior register cascade
    output var  logic        lut_chain_in         // prior lookup cascade
);
    // prior cluster runs no chain, so adders start in element 0
    initial
    begin
        data_in = 40'h0000000000;
        {cluster_carry_in, zero_chain_carry_in, one_chain_carry_in} = 3'h0;
        {reg_chain_in, lut_chain_in} = 2'h0;
    end

    // routing changes data just after a clock edge
    task automatic set_data(input logic [39:0] d);
        @(posedge aclk);
        data_in <= d;
    endtask
endmodule // ple_nbr_model
`default_nettype wire

// file: sim/programmable_logic_element_tb_top.sv
// self-checking bench for the programmable logic cluster
`timescale 1ns/10ps
`default_nettype none
module programmable_logic_element_tb_top;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [1:0]  cclk = 2'h0, cen = 2'h3, aclr = 2'h0;
    logic        aload = 1'h0, sclr = 1'h0, sload = 1'h0, pin_n = 1'h1;
    logic        awready, wready, bvalid, arready, rvalid, gp, cluster_carry_in;
    logic        zero_chain_carry_in, one_chain_carry_in, reg_chain_in, lut_chain_in;
    logic        zero_chain_carry_out, one_chain_carry_out, cluster_carry_out;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  lo_loc, lo_row, lo_col;
    logic [39:0] data_in, dv;
    logic [3:0]  ex;
    logic [3:0]  aa [4] = '{4'h5, 4'h3, 4'h9, 4'hF};
    logic [3:0]  bb [4] = '{4'h3, 4'h5, 4'h9, 4'h1};
    int          k, j;
    int          n_fail = 0;
    int          checked = 0;

    // 20 mhz clock
    always #25 aclk = ~aclk;

    ple_nbr_model u_nbr (.*);

    ple_cluster u_dut (.*, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cluster_clk(cclk), .cluster_clk_en(cen), .async_clear(aclr),
        .async_load(aload), .sync_clear(sclr), .sync_load(sload),
        .chip_wide_clear_n(pin_n), .le_out_local(lo_loc), .le_out_row(lo_row),
        .le_out_col(lo_col), .reg_chain_out(), .lut_chain_out(), .gp_pin_level(gp));

    // counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // word and bit comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp, input string what);
        chk({31'h0, got}, {31'h0, exp}, what);
    endtask

    // a used-up wait counts as a mismatch and ends the run
    task automatic lim(input int i);
        if (i == 40)
        begin
            n_fail++;
            test_done();
        end
    endtask

    // bus write: address and data together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        bready <= 1'h0;
        lim(i);
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask

    // bus read, masked data compare
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er = 2'h0);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        rready <= 1'h0;
        lim(i);
        chk(rdata & m, e, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask

    // one tick of cluster clock 0, then outputs settle
    task automatic tick;
        @(posedge aclk);
        cclk <= 2'h1;
        @(posedge aclk);
        cclk <= 2'h0;
        repeat (3) @(posedge aclk);
    endtask

    // asynchronous load of the fourth data input
    task automatic load_q(input logic v);
        u_nbr.set_data({36'h0, v, 3'h0});
        aload <= 1'h1;
        repeat (3) @(posedge aclk);
        aload <= 1'h0;
    endtask

    // main sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h04, 32'h3FF, 32'h0);
        wr(8'h64, 32'hFFFFFFFF);
        rd(8'h64, 32'hFFFFFFFF, 32'h7FFFFFFF);
        wr(8'h64, 32'h0);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h3FF, 32'h0);
        wr(8'h80, 32'h1, 2'h2);
        rd(8'h80, 32'hFFFFFFFF, 32'h0, 2'h2);
        $display("test registers done");
        wr(8'h40, 32'h6B2D);
        for (k = 0; k < 16; k++)
        begin
            u_nbr.set_data({36'h0, k[3:0]});
            repeat (3) @(posedge aclk);
            chkb(lo_loc[0], k[3:0] inside {0, 2, 3, 5, 8, 9, 11, 13, 14}, "lut");
            chkb(lo_col[0], lo_loc[0], "bypass");
        end
        $display("test lookup done");
        for (k = 0; k < 4; k++)
        begin
            wr(8'h40, 32'h0040AAAA | {13'h0, k[1:0], 17'h0});
            load_q(k[0]);
            chkb(lo_row[0], k[0], "async load");
            u_nbr.set_data({36'h0, k[1], 2'h0, ~(k[0] & k[1])});
            tick();
            chkb(lo_row[0], ~k[0], "ff mode");
            chkb(lo_loc[0], ~(k[0] & k[1]), "lut beside ff");
        end
        wr(8'h40, 32'h0040AAAA);
        cen <= 2'h2;
        u_nbr.set_data(40'h1);
        tick();
        chkb(lo_row[0], 1'h0, "enable off");
        cen <= 2'h3;
        sclr <= 1'h1;
        sload <= 1'h1;
        u_nbr.set_data(40'h9);
        tick();
        chkb(lo_row[0], 1'h0, "clear first");
        sclr <= 1'h0;
        u_nbr.set_data(40'h8);
        tick();
        chkb(lo_row[0], 1'h1, "sync load");
        sload <= 1'h0;
        aclr <= 2'h1;
        load_q(1'h1);
        chkb(lo_row[0], 1'h0, "clear beats load");
        aclr <= 2'h0;
        wr(8'h40, 32'h4040AAAA);
        load_q(1'h0);
        chkb(lo_row[0], 1'h1, "preset");
        wr(8'h40, 32'h0050CCCC);
        load_q(1'h1);
        chkb(lo_loc[0], 1'h1, "packing");
        $display("test storage done");
        for (k = 0; k < 4; k++)
            wr(8'h40 + {4'h0, k[1:0], 2'h0}, k == 0 ? 32'h10010000 : 32'h00010000);
        for (k = 0; k < 4; k++)
        begin
            wr(8'h00, {30'h0, k[0] ^ k[1], 1'h0});
            dv = 40'h0000000000;
            for (j = 0; j < 4; j++)
                dv[4 * j +: 2] = {bb[k][j], aa[k][j]};
            ex = (k[0] ^ k[1]) ? aa[k] - bb[k] : aa[k] + bb[k];
            u_nbr.set_data(dv);
            repeat (3) @(posedge aclk);
            chk({28'h0, lo_loc[3:0]}, {28'h0, ex}, "sum");
            chkb(zero_chain_carry_out, 1'h0, "chain zero");
            chkb(one_chain_carry_out, k[0] ^ k[1], "chain one");
            chkb(cluster_carry_out, (k[0] ^ k[1]) && aa[k] >= bb[k], "carry");
        end
        $display("test arithmetic done");
        wr(8'h40, 32'h0040AAAA);
        wr(8'h00, 32'h0);
        u_nbr.set_data(40'h9);
        tick();
        pin_n <= 1'h0;
        tick();
        chkb(gp, 1'h0, "pin level");
        chkb(lo_row[0], 1'h1, "pin ignored");
        wr(8'h00, 32'h1);
        aload <= 1'h1;
        repeat (3) @(posedge aclk);
        chkb(lo_row[0], 1'h0, "chip clear");
        rd(8'h04, 32'h800, 32'h800);
        pin_n <= 1'h1;
        aload <= 1'h0;
        $display("test chip clear done");
        test_done();
    end

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done();
    end
endmodule // programmable_logic_element_tb_top
`default_nettype wire
